/* gpio_port_pkg.sv */
// package: register map, field layout and pin carriers for the port block
package gpio_port_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_P0  = 8'h00; // bidir port 0 data latch
  localparam logic [7:0] ADDR_DATA_P2  = 8'h02; // bidir port 2 data latch
  localparam logic [7:0] ADDR_DATA_P3  = 8'h03; // bidir port 3 data latch
  localparam logic [7:0] ADDR_DATA_OD  = 8'h05; // open-drain port data latch
  localparam logic [7:0] ADDR_DATA_OC  = 8'h07; // output-only port data latch
  localparam logic [7:0] ADDR_DIR_P0   = 8'h10; // port 0 direction
  localparam logic [7:0] ADDR_DIR_P2   = 8'h12; // port 2 direction
  localparam logic [7:0] ADDR_DIR_P3   = 8'h13; // port 3 direction
  localparam logic [7:0] ADDR_DIR_OC   = 8'h17; // output-only port direction
  localparam logic [7:0] ADDR_RES_P2   = 8'h20; // port 2 resource select
  localparam logic [7:0] ADDR_RES_OD   = 8'h21; // open-drain resource select
  localparam logic [7:0] ADDR_OC_SEL   = 8'h22; // compare output select
  localparam logic [7:0] ADDR_BUS_SEL  = 8'h23; // bus_signal_select_register
  localparam logic [7:0] ADDR_MODE     = 8'h24; // chip mode
  localparam logic [7:0] ADDR_BITOP    = 8'h25; // read-modify-write bit op
  localparam logic [7:0] ADDR_CMP_A    = 8'h26; // compare_control_reg_a
  localparam logic [7:0] ADDR_CMP_B    = 8'h27; // compare_control_reg_b

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int         BITOP_VAL_BIT  = 7;     // value to put in the bit
  localparam int         BITOP_PORT_LSB = 4;     // port code, 3 bits
  localparam int         BITOP_BIT_LSB  = 0;     // bit number, 3 bits
  localparam int         MODE_EXT_BIT   = 0;     // 1 = external bus mode
  localparam logic [7:0] P2_RES_MASK    = 8'hf0; // selectable upper nibble
  localparam logic [3:0] CMP_LVL_MASK   = 4'hf;  // compare level bits

  // port codes used by the bit operation register
  localparam logic [2:0] PORT_P0 = 3'h0;
  localparam logic [2:0] PORT_P2 = 3'h1;
  localparam logic [2:0] PORT_P3 = 3'h2;
  localparam logic [2:0] PORT_OD = 3'h3;
  localparam logic [2:0] PORT_OC = 3'h4;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] LATCH_RST    = 8'h00; // bidir and output latches
  localparam logic [7:0] OD_LATCH_RST = 8'hff; // open-drain transistors off
  localparam logic [7:0] DIR_RST      = 8'h00; // every pin an input
  localparam logic [7:0] SEL_RST      = 8'h00; // every pin a plain port
  localparam logic [7:0] RDATA_RST    = 8'h00;

  // chip operating mode
  typedef enum logic {
    MODE_SINGLE = 1'b0,
    MODE_EXT    = 1'b1
  } chip_mode_t;

  // one port's pin drive: level and output enable per bit
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

endpackage

/* gpio_ports.sv */
// gpio_ports: bidirectional, open-drain and output-only port logic
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module gpio_ports
  import gpio_port_pkg::*;
(
  input  wire logic                  i_clk,          // 250 MHz system clock
  input  wire logic                  i_rst,          // async, active high
  input  wire logic [7:0]            i_addr,         // register address
  input  wire logic [7:0]            i_wdata,        // register write data
  input  wire logic                  i_wr,           // write strobe
  input  wire logic                  i_rd,           // read strobe
  output logic      [7:0]            o_rdata,        // read data, next cycle
  input  wire logic [2:0][7:0]       i_bd_pin,       // bidir pin levels
  output pin_drive_t [2:0]           o_bd_drive,     // bidir pin drive
  input  wire pin_drive_t [2:0]      i_bus_drive,    // external bus drive
  input  wire pin_drive_t            i_p2_res_drive, // port 2 resource
  input  wire logic [7:0]            i_od_pin,       // open-drain levels
  output pin_drive_t                 o_od_drive,     // open-drain drive
  input  wire logic [7:0]            i_od_res_low,   // resource pulls low
  input  wire logic [7:0]            i_oc_pin,       // output-only levels
  output pin_drive_t                 o_oc_drive,     // output-only drive
  input  wire logic [7:0]            i_cmp_match     // compare match pulses
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // force one bit of a byte to a value
  function automatic logic [7:0] set_bit(input logic [7:0] v,
                                         input logic [2:0] b,
                                         input logic       val);
    logic [7:0] m;
    m = 8'h01 << b;
    return val ? (v | m) : (v & ~m);
  endfunction

  // per bit: output bits give the latch, input bits give the pin
  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                           input logic [7:0] pin,
                                           input logic [7:0] dir);
    return (latch & dir) | (pin & ~dir);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [2:0][7:0] bd_data_r;  // bidir output latches
  logic [2:0][7:0] bd_dir_r;   // bidir direction bits
  logic [2:0][7:0] bd_s1_r;    // bidir pin sync, stage one
  logic [2:0][7:0] bd_s2_r;    // bidir pin sync, stage two
  logic [7:0]      od_data_r;  // open-drain latch
  logic [7:0]      od_res_r;   // open-drain resource select
  logic [7:0]      od_s1_r;    // open-drain sync, stage one
  logic [7:0]      od_s2_r;    // open-drain sync, stage two
  logic [7:0]      oc_data_r;  // output-only latch, never reaches a pin
  logic [7:0]      oc_dir_r;   // output-only direction
  logic [7:0]      oc_sel_r;   // 1 = compare output, 0 = port
  logic [7:0]      oc_s1_r;    // output-only sync, stage one
  logic [7:0]      oc_s2_r;    // output-only sync, stage two
  logic [7:0]      cmp_dot_r;  // compare level bits, pending
  logic [7:0]      cmp_lvl_r;  // compare output latch
  logic [7:0]      p2_res_r;   // port 2 resource select
  logic [7:0]      bus_sel_r;  // port 3 bits returned to port use
  chip_mode_t      mode_r;     // single chip or external bus

  // next values
  logic [2:0][7:0] bd_data_nxt;
  logic [7:0]      od_data_nxt;
  logic [7:0]      oc_data_nxt;
  logic [7:0]      cmp_lvl_nxt;
  pin_drive_t [2:0] bd_drive_nxt;
  pin_drive_t      od_drive_nxt;
  pin_drive_t      oc_drive_nxt;
  logic [7:0]      rdata_nxt;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire        ext_mode = (mode_r == MODE_EXT);
  wire        bitop_wr = i_wr && (i_addr == ADDR_BITOP);
  wire [2:0]  op_port  = i_wdata[BITOP_PORT_LSB +: 3];
  wire [2:0]  op_bit   = i_wdata[BITOP_BIT_LSB +: 3];
  wire        op_val   = i_wdata[BITOP_VAL_BIT];
  wire [2:0]  bd_wr;   // plain data write, one per bidir port
  wire [2:0]  bd_op;   // bit operation, one per bidir port
  wire [2:0]  bd_code [3];

  assign bd_code[0] = PORT_P0;
  assign bd_code[1] = PORT_P2;
  assign bd_code[2] = PORT_P3;
  assign bd_wr[0]   = i_wr && (i_addr == ADDR_DATA_P0);
  assign bd_wr[1]   = i_wr && (i_addr == ADDR_DATA_P2);
  assign bd_wr[2]   = i_wr && (i_addr == ADDR_DATA_P3);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_bdop
      assign bd_op[g] = bitop_wr && (op_port == bd_code[g]);
    end
  endgenerate

  wire od_wr = i_wr && (i_addr == ADDR_DATA_OD);
  wire od_op = bitop_wr && (op_port == PORT_OD);
  wire oc_wr = i_wr && (i_addr == ADDR_DATA_OC);
  wire oc_op = bitop_wr && (op_port == PORT_OC);

  // ----------------------------------------------------------------------
  // latch next values
  // ----------------------------------------------------------------------
  // bidir latches: plain write or bit operation
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      if (bd_wr[k])
        bd_data_nxt[k] = i_wdata;
      else if (bd_op[k])
        bd_data_nxt[k] = set_bit(port_view(bd_data_r[k], bd_s2_r[k],
                                           bd_dir_r[k]), op_bit, op_val);
      else
        bd_data_nxt[k] = bd_data_r[k];
    end
  end
  // open-drain latch: a bit operation starts from the latch, not the pins
  always_comb
  begin
    if (od_wr)
      od_data_nxt = i_wdata;
    else if (od_op)
      od_data_nxt = set_bit(od_data_r, op_bit, op_val);
    else
      od_data_nxt = od_data_r;
  end
  // output-only latch: stored for reads of nothing, kept for software
  always_comb
  begin
    if (oc_wr)
      oc_data_nxt = i_wdata;
    else if (oc_op)
      oc_data_nxt = set_bit(oc_data_r, op_bit, op_val);
    else
      oc_data_nxt = oc_data_r;
  end

  assign cmp_lvl_nxt = (cmp_lvl_r & ~i_cmp_match) | (cmp_dot_r & i_cmp_match);

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  // bidir: port latch, then resource, then external bus on top
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      bd_drive_nxt[k].out = bd_data_r[k];
      bd_drive_nxt[k].oe  = bd_dir_r[k];
    end
    bd_drive_nxt[1].out = (bd_data_r[1] & ~p2_res_r)
                        | (i_p2_res_drive.out & p2_res_r);
    bd_drive_nxt[1].oe  = (bd_dir_r[1] & ~p2_res_r)
                        | (i_p2_res_drive.oe & p2_res_r);
    // bus owns ports 0 and 2 in bus mode, and the port 3 pins not set in bus_sel_r
    if (ext_mode)
    begin
      bd_drive_nxt[0] = i_bus_drive[0];
      bd_drive_nxt[1] = i_bus_drive[1];
      bd_drive_nxt[2].out = (i_bus_drive[2].out & ~bus_sel_r)
                          | (bd_data_r[2] & bus_sel_r);
      bd_drive_nxt[2].oe  = (i_bus_drive[2].oe & ~bus_sel_r)
                          | (bd_dir_r[2] & bus_sel_r);
    end
  end

  assign od_drive_nxt.out = 8'h00;
  assign od_drive_nxt.oe  = (~od_data_r & ~od_res_r)
                          | (i_od_res_low & od_res_r);

  assign oc_drive_nxt.out = cmp_lvl_r;
  assign oc_drive_nxt.oe  = oc_dir_r & oc_sel_r;

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // bidir output bits answer from the latch so a read never lags the write, output-only ones from cmp_lvl_r;
  // input bits and all open-drain bits answer from the synchronised pin, two cycles behind
  always_comb
  begin
    unique case (i_addr)
      ADDR_DATA_P0: rdata_nxt = port_view(bd_data_r[0], bd_s2_r[0],
                                          bd_dir_r[0]);
      ADDR_DATA_P2: rdata_nxt = port_view(bd_data_r[1], bd_s2_r[1],
                                          bd_dir_r[1]);
      ADDR_DATA_P3: rdata_nxt = port_view(bd_data_r[2], bd_s2_r[2],
                                          bd_dir_r[2]);
      ADDR_DATA_OD: rdata_nxt = od_s2_r;
      ADDR_DATA_OC: rdata_nxt = port_view(cmp_lvl_r, oc_s2_r,
                                          oc_dir_r & oc_sel_r);
      ADDR_DIR_P0:  rdata_nxt = bd_dir_r[0];
      ADDR_DIR_P2:  rdata_nxt = bd_dir_r[1];
      ADDR_DIR_P3:  rdata_nxt = bd_dir_r[2];
      ADDR_DIR_OC:  rdata_nxt = oc_dir_r;
      ADDR_RES_P2:  rdata_nxt = p2_res_r;
      ADDR_RES_OD:  rdata_nxt = od_res_r;
      ADDR_OC_SEL:  rdata_nxt = oc_sel_r;
      ADDR_BUS_SEL: rdata_nxt = bus_sel_r;
      ADDR_MODE:    rdata_nxt = {7'h00, mode_r};
      ADDR_CMP_A:   rdata_nxt = {4'h0, cmp_dot_r[3:0]};
      ADDR_CMP_B:   rdata_nxt = {4'h0, cmp_dot_r[7:4]};
      default:      rdata_nxt = RDATA_RST; // unmapped reads give zero
    endcase
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // pins are asynchronous; only stage two feeds any logic
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bd_s1_r <= '0;
      bd_s2_r <= '0;
      od_s1_r <= 8'h00;
      od_s2_r <= 8'h00;
      oc_s1_r <= 8'h00;
      oc_s2_r <= 8'h00;
    end
    else
    begin
      bd_s1_r <= i_bd_pin;
      bd_s2_r <= bd_s1_r;
      od_s1_r <= i_od_pin;
      od_s2_r <= od_s1_r;
      oc_s1_r <= i_oc_pin;
      oc_s2_r <= oc_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bd_dir_r  <= {3{DIR_RST}};
      oc_dir_r  <= DIR_RST;
      p2_res_r  <= SEL_RST;
      od_res_r  <= SEL_RST;
      oc_sel_r  <= SEL_RST;
      bus_sel_r <= SEL_RST;
      mode_r    <= MODE_SINGLE;
      cmp_dot_r <= LATCH_RST;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        ADDR_DIR_P0:  bd_dir_r[0] <= i_wdata;
        ADDR_DIR_P2:  bd_dir_r[1] <= i_wdata;
        ADDR_DIR_P3:  bd_dir_r[2] <= i_wdata;
        ADDR_DIR_OC:  oc_dir_r    <= i_wdata;
        ADDR_RES_P2:  p2_res_r    <= i_wdata & P2_RES_MASK;
        ADDR_RES_OD:  od_res_r    <= i_wdata;
        ADDR_OC_SEL:  oc_sel_r    <= i_wdata;
        ADDR_BUS_SEL: bus_sel_r   <= i_wdata;
        ADDR_MODE:    mode_r      <= chip_mode_t'(i_wdata[MODE_EXT_BIT]);
        ADDR_CMP_A:   cmp_dot_r[3:0] <= i_wdata[3:0] & CMP_LVL_MASK;
        ADDR_CMP_B:   cmp_dot_r[7:4] <= i_wdata[3:0] & CMP_LVL_MASK;
        default:      ; // data latches and unmapped handled elsewhere
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // latches, compare level, read data and pin drive registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bd_data_r  <= {3{LATCH_RST}};
      od_data_r  <= OD_LATCH_RST;
      oc_data_r  <= LATCH_RST;
      cmp_lvl_r  <= LATCH_RST;
      o_rdata    <= RDATA_RST;
      o_bd_drive <= '0;
      o_od_drive <= '0;
      o_oc_drive <= '0;
    end
    else
    begin
      bd_data_r  <= bd_data_nxt;
      od_data_r  <= od_data_nxt;
      oc_data_r  <= oc_data_nxt;
      cmp_lvl_r  <= cmp_lvl_nxt;
      // read data only in the cycle after the strobe
      o_rdata    <= i_rd ? rdata_nxt : RDATA_RST;
      o_bd_drive <= bd_drive_nxt;
      o_od_drive <= od_drive_nxt;
      o_oc_drive <= oc_drive_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  dir_buffer_a: assert property (
    !ext_mode |=> o_bd_drive[0].oe == $past(bd_dir_r[0]))
    else $error("port 0 enable does not follow direction");
  write_to_pin_a: assert property (
    (bd_wr[0] && !ext_mode) ##1 !ext_mode
      |=> o_bd_drive[0].out == $past(i_wdata, 2))
    else $error("port 0 write did not reach pin");
  input_read_a: assert property (
    (i_rd && i_addr == ADDR_DATA_P0 && bd_dir_r[0] == 8'h00)
      |=> o_rdata == $past(bd_s2_r[0]))
    else $error("input read did not return pin level");
  rmw_keep_a: assert property (
    bd_op[0] |=> ((bd_data_r[0] ^ $past(bd_data_r[0]))
                  & $past(bd_dir_r[0]) & ~$past(8'h01 << op_bit)) == 8'h00)
    else $error("bit op disturbed an output bit");
  bus_mode_a: assert property (
    ext_mode |=> o_bd_drive[0] == $past(i_bus_drive[0]))
    else $error("bus mode did not give pins to the bus");
  od_low_a: assert property (
    1'b1 |=> o_od_drive.out == 8'h00 &&
      (o_od_drive.oe & ~$past(od_res_r)) == ~$past(od_data_r | od_res_r))
    else $error("open-drain enable does not match latch");
  od_rmw_a: assert property (
    od_op |=> ((od_data_r ^ $past(od_data_r))
               & ~$past(8'h01 << op_bit)) == 8'h00)
    else $error("open-drain bit op changed other bits");
  oc_pin_a: assert property (
    1'b1 |=> o_oc_drive.out == $past(cmp_lvl_r) &&
      o_oc_drive.oe == $past(oc_dir_r & oc_sel_r))
    else $error("output-only pin shows other than compare level");
  dot_match_a: assert property (
    i_cmp_match[0] |=> cmp_lvl_r[0] == $past(cmp_dot_r[0]) ##1
      o_oc_drive.out[0] == $past(cmp_lvl_r[0]))
    else $error("compare level not taken on match");
  oc_input_a: assert property (
    oc_dir_r == 8'h00 ##1 oc_dir_r == 8'h00 |-> o_oc_drive.oe == 8'h00)
    else $error("output-only pin driven with direction zero");
  // main scenarios
  cover_rmw_c:   cover property (bd_op[2] && bd_dir_r[2] != 8'h00);
  cover_bus_c:   cover property (ext_mode && bus_sel_r != 8'h00);
  cover_match_c: cover property (i_cmp_match != 8'h00 && oc_sel_r != 8'h00);
  cover_od_c:    cover property (od_op && od_res_r == 8'h00);

endmodule

/* multi_type_io_ports_test.sv */
// multi_type_io_ports_test: self-checking bench for the port block
`timescale 1ns/1ns
module multi_type_io_ports_test;
  import gpio_port_pkg::*;
  // -------
  // signals, model state, counters
  // -------
  logic             i_clk = 1'b0;
  logic             i_rst, i_wr, i_rd;
  logic [7:0]       i_addr, i_wdata, o_rdata, i_od_res_low, i_cmp_match;
  logic [7:0]       ext, ext_low, od_pin, oc_pin, d, s, l;
  logic [2:0][7:0]  bd_pin;
  pin_drive_t [2:0] o_bd_drive, i_bus_drive;
  pin_drive_t       o_od_drive, o_oc_drive, i_p2_res_drive, r;
  logic [7:0]       m [256] = '{default: 8'h00}; // model register copy
  logic [31:0]      seed = 32'h6221cd74;
  int               error_cnt = 0, n_tests = 0, cyc = 0;
  logic [7:0]       da [3] = '{ADDR_DATA_P0, ADDR_DATA_P2, ADDR_DATA_P3};
  logic [7:0]       dd [3] = '{ADDR_DIR_P0, ADDR_DIR_P2, ADDR_DIR_P3};

  gpio_ports dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bd_pin(bd_pin),
    .o_bd_drive(o_bd_drive), .i_bus_drive(i_bus_drive),
    .i_p2_res_drive(i_p2_res_drive), .i_od_pin(od_pin),
    .o_od_drive(o_od_drive), .i_od_res_low(i_od_res_low),
    .i_oc_pin(oc_pin), .o_oc_drive(o_oc_drive), .i_cmp_match(i_cmp_match));
  pin_board board (
    .i_bd_drive(o_bd_drive), .i_od_drive(o_od_drive),
    .i_oc_drive(o_oc_drive), .i_ext(ext), .i_ext_low(ext_low),
    .o_bd_pin(bd_pin), .o_od_pin(od_pin), .o_oc_pin(oc_pin));

  // clock, and a ceiling well above the few hundred cycles needed
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  // -------
  // helpers
  // -------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // per bit: a where s is set, b elsewhere
  function automatic logic [7:0] mx(input logic [7:0] s, a, b);
    return (a & s) | (b & ~s);
  endfunction
  task automatic chk8(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkd(input pin_drive_t got, exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    m[a] = v;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk8(o_rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // -------
  // scenarios
  // -------
  initial
  begin
    i_rst = 1'b1;
    {i_wr, i_rd, i_addr, i_wdata, ext, ext_low} = '0;
    {i_od_res_low, i_cmp_match, i_bus_drive, i_p2_res_drive} = '0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (dd[p]) rd(dd[p], DIR_RST);
    rd(8'h3f, RDATA_RST);
    rd(ADDR_DATA_OD, OD_LATCH_RST);
    $display("test reset done");
    // latch loaded before the pin turns to output
    foreach (da[p])
    begin
      d = rnd();
      wr(da[p], d);
      wr(dd[p], 8'hff);
      tick(2);
      chkd(o_bd_drive[p], {d, 8'hff});
      rd(da[p], d);
    end
    $display("test bidir output done");
    repeat (4)
    begin
      s = rnd();
      ext <= rnd();
      wr(ADDR_DIR_P0, s);
      wr(ADDR_DATA_P0, rnd());
      tick(3);
      chkd(o_bd_drive[0], {m[0], s});
      rd(ADDR_DATA_P0, mx(s, m[0], ext));
      d = rnd();
      wr(ADDR_BITOP, {d[7], PORT_P0, 1'b0, d[2:0]});
      m[0] = mx(s, m[0], ext);
      m[0][d[2:0]] = d[7];
      tick(2);
      chkd(o_bd_drive[0], {m[0], s});
    end
    $display("test bidir input done");
    repeat (4)
    begin
      d = rnd();
      wr(ADDR_DATA_OD, d);
      tick(2);
      chkd(o_od_drive, {8'h00, ~d});
      rd(ADDR_DATA_OD, d);
      ext_low <= rnd();
      // let the new pin levels pass the synchroniser before the bit op
      tick(2);
      l = rnd();
      wr(ADDR_BITOP, {l[7], PORT_OD, 1'b0, l[2:0]});
      d[l[2:0]] = l[7];
      tick(3);
      chkd(o_od_drive, {8'h00, ~d});
      rd(ADDR_DATA_OD, d & ~ext_low);
      ext_low <= 8'h00;
    end
    // resource owns the selected open-drain bits
    s = rnd();
    @(posedge i_clk);
    i_od_res_low <= rnd();
    wr(ADDR_RES_OD, s);
    tick(2);
    chkd(o_od_drive, {8'h00, mx(s, i_od_res_low, ~d)});
    $display("test open drain done");
    s = rnd();
    l = rnd();
    ext <= rnd();
    wr(ADDR_DATA_OC, 8'hff);
    wr(ADDR_BITOP, {1'b1, PORT_OC, 4'h0});
    wr(ADDR_DIR_OC, 8'hff);
    wr(ADDR_OC_SEL, s);
    wr(ADDR_CMP_A, {4'h0, l[3:0]});
    wr(ADDR_CMP_B, {4'h0, l[7:4]});
    tick(3);
    chkd(o_oc_drive, {8'h00, s});
    rd(ADDR_DATA_OC, mx(s, 8'h00, ext));
    rd(ADDR_CMP_B, {4'h0, l[7:4]});
    @(posedge i_clk);
    i_cmp_match <= 8'hff;
    @(posedge i_clk);
    i_cmp_match <= 8'h00;
    tick(1);
    chkd(o_oc_drive, {l, s});
    tick(2);
    rd(ADDR_DATA_OC, mx(s, l, ext));
    wr(ADDR_DIR_OC, 8'h00);
    tick(3);
    chkd(o_oc_drive, {l, 8'h00});
    rd(ADDR_DATA_OC, ext);
    $display("test output only done");
    // port 2 resource nibble, then bus mode
    // bit ops on ports 2 and 3
    l = rnd();
    wr(ADDR_BITOP, {l[7], PORT_P2, 1'b0, l[2:0]});
    wr(ADDR_BITOP, {l[6], PORT_P3, 1'b0, l[5:3]});
    m[2][l[2:0]] = l[7];
    m[3][l[5:3]] = l[6];
    r = {rnd(), rnd()};
    @(posedge i_clk);
    i_p2_res_drive <= r;
    wr(ADDR_RES_P2, 8'hff);
    tick(2);
    chkd(o_bd_drive[1], {mx(P2_RES_MASK, r.out, m[2]),
                         mx(P2_RES_MASK, r.oe, m[8'h12])});
    rd(ADDR_RES_P2, P2_RES_MASK);
    s = rnd();
    @(posedge i_clk);
    i_bus_drive <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    wr(ADDR_BUS_SEL, s);
    wr(ADDR_MODE, 8'h01);
    tick(2);
    chkd(o_bd_drive[0], i_bus_drive[0]);
    chkd(o_bd_drive[2], {mx(s, m[3], i_bus_drive[2].out),
                         mx(s, m[8'h13], i_bus_drive[2].oe)});
    $display("test bus mode done");
    give_verdict();
  end
endmodule

/* pin_board.sv */
// pin_board: board-side model of the port pins
`timescale 1ns/1ns
module pin_board
  import gpio_port_pkg::*;
(
  input  wire pin_drive_t [2:0] i_bd_drive, // bidir pin drive
  input  wire pin_drive_t       i_od_drive, // open-drain drive
  input  wire pin_drive_t       i_oc_drive, // output-only drive
  input  wire logic [7:0]       i_ext,      // board level on free pins
  input  wire logic [7:0]       i_ext_low,  // board pulls od pins low
  output logic [2:0][7:0]       o_bd_pin,   // bidir pin levels
  output logic [7:0]            o_od_pin,   // open-drain pin levels
  output logic [7:0]            o_oc_pin    // output-only pin levels
);
  // -------
  // wire resolution
  // -------
  // released bidir bits follow the board
  always_comb
    for (int p = 0; p < 3; p++)
      o_bd_pin[p] = (i_bd_drive[p].oe & i_bd_drive[p].out)
                  | (~i_bd_drive[p].oe & i_ext);
  // pull-up, low when either side sinks current
  assign o_od_pin = ~(i_od_drive.oe | i_ext_low);
  // released output-only bits follow the board
  assign o_oc_pin = (i_oc_drive.oe & i_oc_drive.out)
                  | (~i_oc_drive.oe & i_ext);
endmodule
